// file: design/mcid_pkg.sv
// Package with register map, field layout, reset values and carrier types of the MAC unit.
package mcid_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [5:0] OFS_CMD    = 6'h00;
	localparam logic [5:0] OFS_STATUS = 6'h04;
	localparam logic [5:0] OFS_FLAGS  = 6'h08;
	localparam logic [5:0] OFS_WACC   = 6'h0C;
	localparam logic [5:0] OFS_CACC   = 6'h10;
	localparam logic [5:0] OFS_MPTR   = 6'h14;
	localparam logic [5:0] OFS_SPTR1  = 6'h18;
	localparam logic [5:0] OFS_SPTR2  = 6'h1C;
	localparam logic [5:0] OFS_BYTE   = 6'h20;
	localparam logic [5:0] OFS_START  = 6'h24;

	// Field positions.
	localparam int CMD_OP_LSB    = 0;
	localparam int CMD_CNT_LSB   = 8;
	localparam int CMD_PAGE_BIT  = 16;
	localparam int MPTR_A_LSB    = 0;
	localparam int MPTR_B_LSB    = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_SUSP_BIT = 1;
	localparam int STAT_CNT_LSB  = 8;

	// Reset values.
	localparam logic [31:0] RST_WACC  = 32'h0000_0000;
	localparam logic [15:0] RST_CACC  = 16'h0000;
	localparam logic [7:0]  RST_PTR   = 8'h00;
	localparam logic [23:0] RST_SPTR  = 24'h00_0000;
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// Operand pages, saturation limits and pointer steps.
	localparam logic [23:0] PAGE_LOW_BASE  = 24'h00FE00;
	localparam logic [23:0] PAGE_HIGH_BASE = 24'h0FFE00;
	localparam logic [31:0] SAT_MAX        = 32'h7FFF_FFFF;
	localparam logic [31:0] SAT_MIN        = 32'h8000_0000;
	localparam logic [7:0]  PTR_STEP       = 8'h02;
	localparam logic [23:0] SCAN_STEP      = 24'h00_0002;
	localparam logic [7:0]  TALLY_STEP     = 8'h01;

	// Operation codes written to the command register.
	typedef enum logic [2:0] {
		OP_MAC,
		OP_MACS,
		OP_SAC,
		OP_INC,
		OP_DEC
	} mcid_op_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD_A,
		ST_RD_B,
		ST_CALC
	} mcid_state_t;

	// Flag set; carry sits in bit 0.
	typedef struct packed {
		logic negative;
		logic null_result;
		logic half_carry;
		logic overflow;
		logic carry;
	} mcid_flags_t;

	localparam mcid_flags_t RST_FLAGS = 5'h00;

	// Word read request towards internal data memory.
	typedef struct packed {
		logic        rd;
		logic [23:0] addr;
	} mcid_mem_req_t;

	localparam mcid_mem_req_t RST_MEM = 25'h000_0000;

endpackage

// file: design/mcid_unit.sv
// Multiply-accumulate, correlation and byte increment/decrement datapath with Avalon-MM registers.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module mcid_unit
	import mcid_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	output var  logic        mem_rd,
	output var  logic [23:0] mem_addr,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_rvalid,
	input  wire logic        svc_req,
	output var  logic        svc_block,
	output var  logic        svc_taken,
	output var  logic [23:0] svc_resume_addr
);

	// Merges write data into an old value under the byte enables.
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Bus state.
	logic        wait_q;
	logic        wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	// Core state.
	mcid_state_t   state_q;
	mcid_state_t   state_d;
	mcid_op_t      op_q;
	mcid_op_t      op_d;
	logic [7:0]    cnt_q;
	logic [7:0]    cnt_d;
	logic          page_q;
	logic          page_d;
	logic [7:0]    ptr_a_q;
	logic [7:0]    ptr_a_d;
	logic [7:0]    ptr_b_q;
	logic [7:0]    ptr_b_d;
	logic [23:0]   sptr1_q;
	logic [23:0]   sptr1_d;
	logic [23:0]   sptr2_q;
	logic [23:0]   sptr2_d;
	logic [31:0]   wacc_q;
	logic [31:0]   wacc_d;
	logic [15:0]   cacc_q;
	logic [15:0]   cacc_d;
	mcid_flags_t   flags_q;
	mcid_flags_t   flags_d;
	logic [7:0]    byte_q;
	logic [7:0]    byte_d;
	logic [23:0]   start_q;
	logic [23:0]   start_d;
	logic          susp_q;
	logic          susp_d;
	logic [15:0]   opa_q;
	logic [15:0]   opa_d;
	logic [15:0]   opb_q;
	logic [15:0]   opb_d;
	mcid_mem_req_t mem_q;
	mcid_mem_req_t mem_d;
	logic          block_q;
	logic          block_d;
	logic          taken_q;
	logic          taken_d;
	logic [23:0]   resume_q;
	logic [23:0]   resume_d;

	// Arithmetic terms.
	logic                wr_take;
	logic [31:0]         wmerge;
	logic signed [31:0]  mac_prod;
	logic [32:0]         mac_sum;
	logic                mac_ovf;
	logic [16:0]         sac_diff;
	logic [15:0]         sac_abs;
	logic [16:0]         sac_sum;
	logic                sac_carry;
	logic [7:0]          inc_res;
	logic [7:0]          inc_low;
	logic [7:0]          dec_res;
	logic [7:0]          dec_low;
	logic                calc_mac;
	logic                calc_sac;
	logic                incdec_go;
	mcid_op_t            cmd_op;

	// A write lands at the edge where waitrequest is seen low.
	assign wr_take = avs_write && !wait_q;
	assign wmerge  = avs_address == OFS_WACC ? be_merge(wacc_q, avs_writedata, avs_byteenable)
		: be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
	assign cmd_op  = mcid_op_t'(avs_writedata[CMD_OP_LSB +: 3]);

	// Signed product and 33-bit sum expose overflow as a sign mismatch.
	assign mac_prod = $signed(opa_q) * $signed(opb_q);
	assign mac_sum  = {wacc_q[31], wacc_q} + {mac_prod[31], mac_prod};
	assign mac_ovf  = mac_sum[32] ^ mac_sum[31];

	// Difference of signed words fits 17 bits; its magnitude fits 16.
	assign sac_diff  = {opa_q[15], opa_q} - {opb_q[15], opb_q};
	assign sac_abs   = sac_diff[16] ? 16'(-sac_diff) : sac_diff[15:0];
	assign sac_sum   = {1'b0, cacc_q} + {1'b0, sac_abs};
	assign sac_carry = sac_sum[16];

	// Low seven bits separately reveal the carry or borrow at bit 7.
	assign inc_res = byte_q + 8'h01;
	assign inc_low = {1'b0, byte_q[6:0]} + 8'h01;
	assign dec_res = byte_q - 8'h01;
	assign dec_low = {1'b0, byte_q[6:0]} - 8'h01;

	assign calc_mac  = (state_q == ST_CALC) && (op_q == OP_MAC || op_q == OP_MACS);
	assign calc_sac  = (state_q == ST_CALC) && (op_q == OP_SAC);
	assign incdec_go = wr_take && state_q == ST_IDLE && avs_address == OFS_CMD
		&& (cmd_op == OP_INC || cmd_op == OP_DEC);

	// Bus slave: one wait cycle, read data captured while waitrequest is high.
	always_comb begin
		wait_d  = 1'b1;
		rdata_d = rdata_q;
		if ((avs_read || avs_write) && wait_q) begin
			wait_d = 1'b0;
		end
		if (avs_read && wait_q) begin
			case (avs_address)
				OFS_CMD:    rdata_d = {15'h0000, page_q, 13'h0000, op_q};
				OFS_STATUS: rdata_d = {16'h0000, cnt_q, 6'h00, susp_q, state_q != ST_IDLE};
				OFS_FLAGS:  rdata_d = {27'h000_0000, flags_q};
				OFS_WACC:   rdata_d = wacc_q;
				OFS_CACC:   rdata_d = {16'h0000, cacc_q};
				OFS_MPTR:   rdata_d = {16'h0000, ptr_b_q, ptr_a_q};
				OFS_SPTR1:  rdata_d = {8'h00, sptr1_q};
				OFS_SPTR2:  rdata_d = {8'h00, sptr2_q};
				OFS_BYTE:   rdata_d = {24'h00_0000, byte_q};
				OFS_START:  rdata_d = {8'h00, start_q};
				default:    rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wait_q  <= 1'b1;
			rdata_q <= RST_RDATA;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// Sequencer, register writes and datapath updates.
	always_comb begin
		state_d  = state_q;
		op_d     = op_q;
		cnt_d    = cnt_q;
		page_d   = page_q;
		ptr_a_d  = ptr_a_q;
		ptr_b_d  = ptr_b_q;
		sptr1_d  = sptr1_q;
		sptr2_d  = sptr2_q;
		wacc_d   = wacc_q;
		cacc_d   = cacc_q;
		flags_d  = flags_q;
		byte_d   = byte_q;
		start_d  = start_q;
		susp_d   = susp_q;
		opa_d    = opa_q;
		opb_d    = opb_q;
		block_d  = block_q;
		taken_d  = 1'b0;
		resume_d = resume_q;
		case (state_q)
			ST_IDLE: begin
				if (wr_take) begin
					case (avs_address)
						OFS_CMD: begin
							op_d   = cmd_op;
							page_d = avs_writedata[CMD_PAGE_BIT];
							case (cmd_op)
								OP_MAC, OP_MACS: begin
									// Accumulator is left as software set it.
									cnt_d = avs_writedata[CMD_CNT_LSB +: 8];
									if (avs_writedata[CMD_CNT_LSB +: 8] == 8'h00) begin
										flags_d.overflow = 1'b0;
									end else begin
										flags_d.overflow = 1'b0;
										state_d          = ST_RD_A;
										block_d          = 1'b1;
									end
								end
								OP_SAC: begin
									susp_d = 1'b0;
									cnt_d  = ptr_b_q;
									if (ptr_b_q == 8'h00) begin
										flags_d.carry = 1'b0;
									end else begin
										state_d = ST_RD_A;
									end
								end
								OP_INC: begin
									byte_d               = inc_res;
									flags_d.null_result  = inc_res == 8'h00;
									flags_d.half_carry   = byte_q[3:0] == 4'hF;
									flags_d.negative     = inc_res[7];
									flags_d.overflow     = inc_low[7] && byte_q != 8'hFF;
								end
								OP_DEC: begin
									byte_d               = dec_res;
									flags_d.null_result  = dec_res == 8'h00;
									flags_d.half_carry   = byte_q[3:0] == 4'h0;
									flags_d.negative     = dec_res[7];
									flags_d.overflow     = dec_low[7] && byte_q != 8'h00;
								end
								default: begin
									op_d = op_q;
								end
							endcase
						end
						OFS_FLAGS: flags_d = mcid_flags_t'(wmerge[4:0]);
						OFS_WACC:  wacc_d  = wmerge;
						OFS_CACC:  cacc_d  = wmerge[15:0];
						OFS_MPTR: begin
							ptr_a_d = wmerge[MPTR_A_LSB +: 8];
							ptr_b_d = wmerge[MPTR_B_LSB +: 8];
						end
						OFS_SPTR1: sptr1_d = wmerge[23:0];
						OFS_SPTR2: sptr2_d = wmerge[23:0];
						OFS_BYTE:  byte_d  = wmerge[7:0];
						OFS_START: start_d = wmerge[23:0];
						default:   start_d = start_q;
					endcase
				end
			end
			ST_RD_A: begin
				if (mem_rvalid) begin
					opa_d   = mem_rdata;
					state_d = ST_RD_B;
				end
			end
			ST_RD_B: begin
				if (mem_rvalid) begin
					opb_d   = mem_rdata;
					state_d = ST_CALC;
				end
			end
			ST_CALC: begin
				if (op_q == OP_SAC) begin
					cacc_d        = sac_sum[15:0];
					sptr1_d       = sptr1_q + SCAN_STEP;
					sptr2_d       = sptr2_q + SCAN_STEP;
					flags_d.carry = sac_carry;
					cnt_d         = ptr_b_q - TALLY_STEP;
					if (sac_carry) begin
						state_d = ST_IDLE;
					end else begin
						ptr_b_d = ptr_b_q - TALLY_STEP;
						if (ptr_b_q == TALLY_STEP) begin
							state_d = ST_IDLE;
						end else if (svc_req) begin
							// Yield between steps; restarting the command resumes the scan.
							state_d  = ST_IDLE;
							susp_d   = 1'b1;
							taken_d  = 1'b1;
							resume_d = start_q;
						end else begin
							state_d = ST_RD_A;
						end
					end
				end else if (mac_ovf) begin
					// Pointers and count keep their pre-overflow values.
					flags_d.overflow = 1'b1;
					wacc_d           = op_q == OP_MACS ? (mac_sum[32] ? SAT_MIN : SAT_MAX)
						: mac_sum[31:0];
					state_d          = ST_IDLE;
					block_d          = 1'b0;
				end else begin
					wacc_d  = mac_sum[31:0];
					ptr_a_d = ptr_a_q + PTR_STEP;
					ptr_b_d = ptr_b_q + PTR_STEP;
					cnt_d   = cnt_q - TALLY_STEP;
					if (cnt_q == TALLY_STEP) begin
						state_d = ST_IDLE;
						block_d = 1'b0;
					end else begin
						state_d = ST_RD_A;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Memory request follows the next state and the next pointer values.
	always_comb begin
		mem_d.rd = state_d == ST_RD_A || state_d == ST_RD_B;
		if (op_d == OP_SAC) begin
			mem_d.addr = state_d == ST_RD_B ? sptr2_d : sptr1_d;
		end else begin
			mem_d.addr = (page_d ? PAGE_HIGH_BASE : PAGE_LOW_BASE)
				| {16'h0000, (state_d == ST_RD_B ? ptr_b_d : ptr_a_d)};
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q  <= ST_IDLE;
			op_q     <= OP_MAC;
			cnt_q    <= RST_PTR;
			page_q   <= 1'b0;
			ptr_a_q  <= RST_PTR;
			ptr_b_q  <= RST_PTR;
			sptr1_q  <= RST_SPTR;
			sptr2_q  <= RST_SPTR;
			wacc_q   <= RST_WACC;
			cacc_q   <= RST_CACC;
			flags_q  <= RST_FLAGS;
			byte_q   <= RST_BYTE;
			start_q  <= RST_SPTR;
			susp_q   <= 1'b0;
			opa_q    <= RST_CACC;
			opb_q    <= RST_CACC;
			mem_q    <= RST_MEM;
			block_q  <= 1'b0;
			taken_q  <= 1'b0;
			resume_q <= RST_SPTR;
		end else begin
			state_q  <= state_d;
			op_q     <= op_d;
			cnt_q    <= cnt_d;
			page_q   <= page_d;
			ptr_a_q  <= ptr_a_d;
			ptr_b_q  <= ptr_b_d;
			sptr1_q  <= sptr1_d;
			sptr2_q  <= sptr2_d;
			wacc_q   <= wacc_d;
			cacc_q   <= cacc_d;
			flags_q  <= flags_d;
			byte_q   <= byte_d;
			start_q  <= start_d;
			susp_q   <= susp_d;
			opa_q    <= opa_d;
			opb_q    <= opb_d;
			mem_q    <= mem_d;
			block_q  <= block_d;
			taken_q  <= taken_d;
			resume_q <= resume_d;
		end
	end

	// Outputs straight from flip-flops.
	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign mem_rd          = mem_q.rd;
	assign mem_addr        = mem_q.addr;
	assign svc_block       = block_q;
	assign svc_taken       = taken_q;
	assign svc_resume_addr = resume_q;

	// A good MAC step moves both pointers by two.
	property p_mac_ptr_step;
		@(posedge clk) disable iff (sys_rst)
		calc_mac && !mac_ovf |=> ptr_a_q == $past(ptr_a_q) + PTR_STEP
			&& ptr_b_q == $past(ptr_b_q) + PTR_STEP;
	endproperty
	a_mac_ptr_step: assert property (p_mac_ptr_step) else $error("MAC pointer step wrong");

	// A good MAC step consumes one count and stores the sum.
	property p_mac_count;
		@(posedge clk) disable iff (sys_rst)
		calc_mac && !mac_ovf |=> cnt_q == $past(cnt_q) - TALLY_STEP
			&& wacc_q == $past(mac_sum[31:0]);
	endproperty
	a_mac_count: assert property (p_mac_count) else $error("MAC count or sum wrong");

	// The last step or an overflow ends the MAC and lifts the service block.
	property p_mac_end;
		@(posedge clk) disable iff (sys_rst)
		calc_mac && (mac_ovf || cnt_q == 8'h01) |=> state_q == ST_IDLE && !svc_block;
	endproperty
	a_mac_end: assert property (p_mac_end) else $error("MAC did not end");

	// Overflow keeps pointers and raises the overflow flag.
	property p_mac_ovf_hold;
		@(posedge clk) disable iff (sys_rst)
		calc_mac && mac_ovf |=> ptr_a_q == $past(ptr_a_q) && ptr_b_q == $past(ptr_b_q)
			&& flags_q.overflow;
	endproperty
	a_mac_ovf_hold: assert property (p_mac_ovf_hold) else $error("MAC overflow state wrong");

	// Saturating MAC loads the limit matching the overflow direction.
	property p_mac_sat;
		@(posedge clk) disable iff (sys_rst)
		calc_mac && op_q == OP_MACS && mac_ovf
			|=> wacc_q == ($past(mac_sum[32]) ? SAT_MIN : SAT_MAX);
	endproperty
	a_mac_sat: assert property (p_mac_sat) else $error("Saturation value wrong");

	// MAC reads stay inside the selected page.
	property p_mac_page;
		@(posedge clk) disable iff (sys_rst)
		mem_q.rd && op_q != OP_SAC
			|-> mem_q.addr[23:8] == (page_q ? PAGE_HIGH_BASE[23:8] : PAGE_LOW_BASE[23:8]);
	endproperty
	a_mac_page: assert property (p_mac_page) else $error("MAC address outside page");

	// Service stays blocked for the whole MAC run.
	property p_mac_block;
		@(posedge clk) disable iff (sys_rst)
		state_q != ST_IDLE && op_q != OP_SAC |-> svc_block && !svc_taken;
	endproperty
	a_mac_block: assert property (p_mac_block) else $error("Service not blocked in MAC");

	// The first MAC read finds the accumulator untouched.
	property p_mac_no_clear;
		@(posedge clk) disable iff (sys_rst)
		state_q == ST_IDLE ##1 state_q == ST_RD_A && op_q != OP_SAC
			|-> wacc_q == $past(wacc_q);
	endproperty
	a_mac_no_clear: assert property (p_mac_no_clear) else $error("Accumulator cleared");

	// A carry ends the scan with the tally held and pointers advanced.
	property p_sac_carry;
		@(posedge clk) disable iff (sys_rst)
		calc_sac && sac_carry |=> state_q == ST_IDLE && flags_q.carry
			&& ptr_b_q == $past(ptr_b_q) && sptr1_q == $past(sptr1_q) + SCAN_STEP;
	endproperty
	a_sac_carry: assert property (p_sac_carry) else $error("Correlation carry end wrong");

	// A plain correlation step moves pointers and lowers the tally.
	property p_sac_step;
		@(posedge clk) disable iff (sys_rst)
		calc_sac && !sac_carry |=> ptr_b_q == $past(ptr_b_q) - TALLY_STEP
			&& sptr2_q == $past(sptr2_q) + SCAN_STEP && !flags_q.carry;
	endproperty
	a_sac_step: assert property (p_sac_step) else $error("Correlation step wrong");

	// A pending request between steps yields with the start address.
	property p_sac_yield;
		@(posedge clk) disable iff (sys_rst)
		calc_sac && !sac_carry && ptr_b_q != 8'h01 && svc_req
			|=> svc_taken && svc_resume_addr == $past(start_q) && state_q == ST_IDLE;
	endproperty
	a_sac_yield: assert property (p_sac_yield) else $error("Correlation did not yield");

	// Increment and decrement keep carry and flag the result.
	property p_incdec_flags;
		@(posedge clk) disable iff (sys_rst)
		incdec_go |=> flags_q.carry == $past(flags_q.carry)
			&& flags_q.null_result == (byte_q == 8'h00) && flags_q.negative == byte_q[7];
	endproperty
	a_incdec_flags: assert property (p_incdec_flags) else $error("Byte flags wrong");

	// Computation only follows the second operand read.
	property p_reads_first;
		@(posedge clk) disable iff (sys_rst)
		state_q == ST_CALC |-> $past(state_q) == ST_RD_B && $past(mem_rvalid);
	endproperty
	a_reads_first: assert property (p_reads_first) else $error("Compute before reads");

endmodule // mcid_unit

`default_nettype wire

// file: verification/mcid_mem_model.sv
// Behavioural internal data memory answering word reads after a chosen delay.
`timescale 1ns/10ps
`default_nettype none
module mcid_mem_model (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        mem_rd,
	input  wire logic [23:0] mem_addr,
	input  wire logic [1:0]  lat,
	output var  logic [15:0] mem_rdata,
	output var  logic        mem_rvalid
);
	logic [15:0] m [logic [23:0]];
	logic [1:0]  wait_q;

	// Waits lat cycles per read, gives one word per pulse and scrambles the data lines otherwise.
	always @(posedge clk) begin
		if (sys_rst) begin
			wait_q <= 2'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 16'h5A5A;
		end else if (!mem_rd || mem_rvalid) begin
			wait_q <= 2'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (wait_q == lat) begin
			mem_rvalid <= 1'b1;
			mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : 16'hA5A5;
		end else begin
			wait_q <= wait_q + 2'h1;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule // mcid_mem_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the multiply-accumulate, correlation and byte add/subtract unit.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mcid_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        mem_rd;
	logic        mem_rvalid;
	logic        svc_req = 1'b0;
	logic        svc_block;
	logic        svc_taken;
	logic [23:0] mem_addr;
	logic [23:0] svc_resume_addr;
	logic [15:0] mem_rdata;
	logic [1:0]  lat = 2'h0;
	logic [15:0] rng = 16'hEB9E;
	logic        in_mac = 1'b0;
	logic [31:0] r;
	int          mismatches = 0;
	int          compares = 0;

	mcid_unit DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .svc_req(svc_req),
		.svc_block(svc_block), .svc_taken(svc_taken), .svc_resume_addr(svc_resume_addr));
	mcid_mem_model mm (.clk(clk), .sys_rst(sys_rst), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.lat(lat), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

	// Clock of 5 ns period.
	always #2.5 clk = ~clk;

	function automatic logic [15:0] nxt();
		rng = {rng[14:0], rng[15] ^ rng[13] ^ rng[12] ^ rng[10]};
		return rng;
	endfunction

	task automatic end_sim();
		if (mismatches == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer: request held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rdchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r & m, e);
	endtask

	// Polls the busy bit; only the watchdog ends a run that never finishes.
	task automatic idle();
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
		end while (r[STAT_BUSY_BIT] !== 1'b0);
	endtask

	// Reference sum of products, then the same run on the unit.
	task automatic mac(input logic [2:0] op, input logic pg, input logic [7:0] cnt,
		input logic [31:0] acc0, input logic [15:0] fa, input logic [15:0] fb, input logic rnd);
		longint acc, s;
		logic [7:0] p, q;
		logic [23:0] bs;
		logic ov;
		bs = pg ? PAGE_HIGH_BASE : PAGE_LOW_BASE;
		acc = longint'($signed(acc0));
		p = 8'h10;
		q = 8'h80;
		ov = 1'b0;
		for (int i = 0; i < cnt && !ov; i++) begin
			mm.m[bs | p] = rnd ? nxt() : fa;
			mm.m[bs | q] = rnd ? nxt() : fb;
			s = acc + longint'($signed(mm.m[bs | p])) * longint'($signed(mm.m[bs | q]));
			ov = s > 64'sh7FFFFFFF || s < -64'sh80000000;
			if (ov)
				acc = s > 0 ? 64'sh7FFFFFFF : -64'sh80000000;
			else begin
				acc = s;
				p = p + PTR_STEP;
				q = q + PTR_STEP;
			end
		end
		lat <= 2'(nxt());
		bus(1'b1, OFS_WACC, acc0);
		bus(1'b1, OFS_MPTR, 32'h8010);
		bus(1'b1, OFS_FLAGS, 32'h0);
		in_mac <= 1'b1;
		svc_req <= 1'b1;
		bus(1'b1, OFS_CMD, {15'h0, pg, cnt, 5'h0, op});
		bus(1'b1, OFS_WACC, 32'h0);
		// With no step to run the unit stays idle, so this write lands.
		if (cnt == 8'h00)
			acc = 0;
		idle();
		in_mac <= 1'b0;
		svc_req <= 1'b0;
		if (!ov || op == OP_MACS)
			rdchk(OFS_WACC, 32'hFFFFFFFF, acc[31:0]);
		rdchk(OFS_MPTR, 32'hFFFF, {16'h0, q, p});
		rdchk(OFS_FLAGS, 32'h2, {30'h0, ov, 1'b0});
	endtask

	// Reference correlation run, optionally interrupted by a service request.
	task automatic sac(input logic [7:0] t0, input logic [15:0] c0, input logic [15:0] msk,
		input logic sv);
		int a, s;
		logic [15:0] acc;
		logic [23:0] x, y;
		logic [7:0] t;
		logic cy;
		acc = c0;
		x = 24'h00FE20;
		y = 24'h00FE60;
		t = t0;
		cy = 1'b0;
		while (t != 8'h00 && !cy) begin
			mm.m[x] = nxt() & msk;
			mm.m[y] = nxt() & msk;
			a = $signed(mm.m[x]) - $signed(mm.m[y]);
			s = acc + (a < 0 ? -a : a);
			cy = s[16];
			acc = s[15:0];
			x = x + SCAN_STEP;
			y = y + SCAN_STEP;
			if (!cy)
				t = t - TALLY_STEP;
		end
		bus(1'b1, OFS_CACC, {16'h0, c0});
		bus(1'b1, OFS_SPTR1, 32'h00FE20);
		bus(1'b1, OFS_SPTR2, 32'h00FE60);
		bus(1'b1, OFS_MPTR, {16'h0, t0, 8'h00});
		bus(1'b1, OFS_FLAGS, 32'h1);
		bus(1'b1, OFS_START, 32'h012340);
		svc_req <= sv;
		bus(1'b1, OFS_CMD, {29'h0, OP_SAC});
		if (sv) begin
			while (svc_taken !== 1'b1) begin
				@(posedge clk);
			end
			chk({8'h0, svc_resume_addr}, 32'h012340);
			svc_req <= 1'b0;
			rdchk(OFS_STATUS, 32'h2, 32'h2);
			bus(1'b1, OFS_CMD, {29'h0, OP_SAC});
		end
		idle();
		rdchk(OFS_CACC, 32'hFFFF, {16'h0, acc});
		rdchk(OFS_SPTR1, 32'hFFFFFF, {8'h0, x});
		rdchk(OFS_SPTR2, 32'hFFFFFF, {8'h0, y});
		rdchk(OFS_MPTR, 32'hFF00, {16'h0, t, 8'h00});
		rdchk(OFS_FLAGS, 32'h1, {31'h0, cy});
	endtask

	// Byte add-one and subtract-one over boundary values with a random carry flag that must be kept.
	task automatic incdec();
		logic [7:0] vals [8];
		logic [7:0] v, e;
		logic [15:0] u;
		logic dn;
		vals = '{8'h7F, 8'hFF, 8'h0F, 8'h80, 8'h00, 8'h10, 8'h70, 8'h01};
		for (int i = 0; i < 16; i++) begin
			v = vals[i % 8];
			u = nxt();
			dn = i > 7;
			e = dn ? v - 8'h01 : v + 8'h01;
			bus(1'b1, OFS_FLAGS, {31'h0, u[0]});
			bus(1'b1, OFS_BYTE, {24'h0, v});
			bus(1'b1, OFS_CMD, {29'h0, dn ? OP_DEC : OP_INC});
			rdchk(OFS_BYTE, 32'hFF, {24'h0, e});
			rdchk(OFS_FLAGS, 32'hFFFFFFFF, {27'h0, e[7], e == 8'h00,
				dn ? v[3:0] == 4'h0 : v[3:0] == 4'hF, dn ? v == 8'h80 : v == 8'h7F, u[0]});
		end
	endtask

	// Service stays blocked and untaken while a multiply-accumulate fetches operands.
	always @(posedge clk)
		if (in_mac && mem_rd)
			chk({30'h0, svc_block, svc_taken}, 32'h2);

	// Main sequence.
	initial begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk(OFS_WACC, 32'hFFFFFFFF, RST_WACC);
		rdchk(6'h3C, 32'hFFFFFFFF, 32'h0);
		mac(OP_MAC, 1'b0, 8'h03, 32'h00000005, 16'h0, 16'h0, 1'b1);
		mac(OP_MAC, 1'b1, 8'h04, 32'hFFFFFF00, 16'h0, 16'h0, 1'b1);
		mac(OP_MAC, 1'b0, 8'h03, 32'h40000000, 16'h7FFF, 16'h7FFF, 1'b0);
		mac(OP_MACS, 1'b1, 8'h03, 32'h40000000, 16'h7FFF, 16'h7FFF, 1'b0);
		mac(OP_MACS, 1'b0, 8'h02, 32'h80000000, 16'h8000, 16'h7FFF, 1'b0);
		mac(OP_MACS, 1'b0, 8'h00, 32'h12345678, 16'h0, 16'h0, 1'b1);
		mac(OP_MACS, 1'b0, 8'h05, 32'h00000000, 16'h0, 16'h0, 1'b1);
		sac(8'h04, 16'h0000, 16'h0FFF, 1'b1);
		sac(8'h05, 16'hFFF0, 16'hFFFF, 1'b0);
		sac(8'h03, 16'h0100, 16'h00FF, 1'b0);
		incdec();
		end_sim();
	end

	// Cuts a hang short.
	initial begin
		#300000;
		mismatches++;
		end_sim();
	end
endmodule // testbench
`default_nettype wire
